// file: core/pid_defs.svh
`ifndef PID_DEFS_SVH
`define PID_DEFS_SVH

// register byte offsets
`define ADDR_CTRL      8'h00
`define ADDR_SETPOINT  8'h04
`define ADDR_PGAIN     8'h08
`define ADDR_ISET      8'h0C
`define ADDR_DSET      8'h10
`define ADDR_MANPWR    8'h14
`define ADDR_STATUS    8'h18
`define ADDR_HEATER    8'h1C
`define ADDR_ERROR     8'h20
`define ADDR_FEEDBACK  8'h24

// control and status field positions
`define CTRL_CLOSED_BIT 0
`define CTRL_ICLR_BIT   1
`define STAT_LOOP_BIT   0
`define STAT_SATHI_BIT  1
`define STAT_SATLO_BIT  2

// reset values
`define CTRL_RST   2'h0
`define SET_RST    16'h0000

// scaling: heater and manual power in 0.01 % steps
`define FULL_SCALE 16'h2710
`define DSET_MAX   16'h00C8
`define I_NUMER    1000
`define D_QUARTER  250
`define D_PERCENT  100
`define P_SHIFT    8

// timing
`define CLK_HZ           40000000
`define UPDATE_PERIOD_US 100000
`define UPDATE_HZ        10

`endif

// file: core/pid_pkg.sv
package pid_pkg;

  // control loop sequencing
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_PROP = 3'b001,
    S_INTG = 3'b010,
    S_DIV  = 3'b011,
    S_SUM  = 3'b100
  } loop_state_e;

  // software control bits
  typedef struct packed {
    logic iclr;
    logic closed;
  } ctrl_s;

  // loop status seen by software
  typedef struct packed {
    logic sat_lo;
    logic sat_hi;
    logic loop_on;
  } status_s;

endpackage

// file: core/pid_div.sv
`timescale 1ns/1ps
module pid_div #(
  parameter int NW = 48,
  parameter int DW = 24
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // request
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  // answer
  output logic               done,
  output logic [NW-1:0]      quot
);

  localparam int CW = $clog2(NW + 1);

  logic [DW:0]   rem_r;
  logic [NW-1:0] quo_r;
  logic [DW-1:0] den_r;
  logic [CW-1:0] cnt_r;
  logic          busy_r;
  logic [DW:0]   trial;

  // one restoring step per cycle
  assign trial = {rem_r[DW-1:0], quo_r[NW-1]};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rem_r  <= '0;
      quo_r  <= '0;
      den_r  <= '0;
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done   <= 1'b0;
      quot   <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rem_r  <= '0;
        quo_r  <= num;
        den_r  <= den;
        cnt_r  <= CW'(NW);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (trial >= {1'b0, den_r}) begin
          rem_r <= trial - {1'b0, den_r};
          quo_r <= {quo_r[NW-2:0], 1'b1};
        end else begin
          rem_r <= trial;
          quo_r <= {quo_r[NW-2:0], 1'b0};
        end
        cnt_r <= cnt_r - 1'b1;
        if (cnt_r == CW'(1)) begin
          busy_r <= 1'b0;
          done   <= 1'b1; // quotient final on this step
          quot   <= {quo_r[NW-2:0], (trial >= {1'b0, den_r})};
        end
      end
    end
  end

endmodule

// file: core/pid_heater_control_law.sv
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "pid_defs.svh"
module pid_heater_control_law
  import pid_pkg::*;
#(
  parameter int UPDATE_CYCLES =
    (`CLK_HZ / 1000000) * `UPDATE_PERIOD_US,
  parameter int UPDATE_HZ     = `UPDATE_HZ
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // sensor feedback reading
  input  wire logic [15:0] FEEDBACK,
  // heater drive, 0.01 % steps of full scale
  output logic      [15:0] HEATER_OUT,
  output logic             HEATER_UPDATE
);

  localparam int TW = $clog2(UPDATE_CYCLES + 1);
  localparam logic signed [47:0] ISCALE = 48'(`I_NUMER * UPDATE_HZ);
  localparam logic [15:0] DK = 16'(`D_QUARTER * UPDATE_HZ);
  localparam logic signed [21:0] PMAX = 22'sh0FFFFF;
  localparam logic signed [21:0] PMIN = -22'sh0FFFFF;
  localparam logic signed [47:0] AMAX =
    48'($signed({1'b0, `FULL_SCALE})) * ISCALE;

  // byte lane merge for partial writes
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  sel);
    merge16 = {sel[1] ? wd[15:8] : old[15:8],
               sel[0] ? wd[7:0]  : old[7:0]};
  endfunction

  // limit a wide signed value to a 22-bit signed term
  function automatic logic signed [21:0] sat22(input logic signed [49:0] v);
    if (v > 50'(PMAX))
      sat22 = PMAX;
    else if (v < 50'(PMIN))
      sat22 = PMIN;
    else
      sat22 = v[21:0];
  endfunction

  ctrl_s               ctrl_r;
  status_s             stat_r;
  loop_state_e         state_r;
  logic [15:0]         setpoint_r;
  logic [15:0]         pgain_r;
  logic [15:0]         iset_r;
  logic [15:0]         dset_r;
  logic [15:0]         manpwr_r;
  logic [15:0]         fb_r;
  logic [TW-1:0]       tick_cnt_r;
  logic                tick_r;
  logic                bus_req;
  logic                bus_wr;
  logic signed [16:0]  err_r;
  logic signed [16:0]  err_prev_r;
  logic signed [21:0]  pterm_r;
  logic signed [21:0]  dterm_r;
  logic                dneg_r;
  logic [19:0]         dmag_r;
  logic signed [34:0]  dabs;
  logic signed [21:0]  dsat;
  logic                over_fs;
  logic                under_zero;
  logic signed [47:0]  acc_r;
  logic signed [33:0]  pprod;
  logic signed [17:0]  derr;
  logic signed [34:0]  dprod;
  logic signed [47:0]  acc_sum;
  logic signed [47:0]  integ;
  logic                loop_on;
  logic                use_d;
  logic                div_start;
  logic [47:0]         div_num;
  logic [23:0]         div_den;
  logic                div_done;
  logic [47:0]         div_quot;
  logic signed [49:0]  total;
  logic [31:0]         rd_data;

  // bus request qualified, write lands on the ack edge
  assign bus_req = WB_CYC_I & WB_STB_I;
  assign bus_wr  = bus_req & WB_WE_I & WB_ACK_O;

  // loop runs only in closed loop with a gain above zero
  assign loop_on = ctrl_r.closed & (pgain_r != 16'h0000);

  // ack one cycle after request, dropped the cycle after
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= bus_req & ~WB_ACK_O;
      WB_DAT_O <= (bus_req & ~WB_ACK_O & ~WB_WE_I) ? rd_data
                                                   : 32'h0000_0000;
    end
  end

  // read decode, unmapped reads as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (WB_ADR_I)
      `ADDR_CTRL:     rd_data = {30'h0, ctrl_r};
      `ADDR_SETPOINT: rd_data = {16'h0, setpoint_r};
      `ADDR_PGAIN:    rd_data = {16'h0, pgain_r};
      `ADDR_ISET:     rd_data = {16'h0, iset_r};
      `ADDR_DSET:     rd_data = {16'h0, dset_r};
      `ADDR_MANPWR:   rd_data = {16'h0, manpwr_r};
      `ADDR_STATUS:   rd_data = {29'h0, stat_r};
      `ADDR_HEATER:   rd_data = {16'h0, HEATER_OUT};
      `ADDR_ERROR:    rd_data = {{15{err_r[16]}}, err_r};
      `ADDR_FEEDBACK: rd_data = {16'h0, fb_r};
      default:        rd_data = 32'h0000_0000;
    endcase
  end

  // software settings, clear bit is a one-shot
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_r     <= `CTRL_RST;
      setpoint_r <= `SET_RST;
      pgain_r    <= `SET_RST;
      iset_r     <= `SET_RST;
      dset_r     <= `SET_RST;
      manpwr_r   <= `SET_RST;
    end else begin
      // pending clear is consumed by the integral pass
      if (state_r == S_INTG)
        ctrl_r.iclr <= 1'b0;
      if (bus_wr) begin
        unique case (WB_ADR_I)
          `ADDR_CTRL: begin
            if (WB_SEL_I[0]) begin
              ctrl_r.closed <= WB_DAT_I[`CTRL_CLOSED_BIT];
              ctrl_r.iclr   <= WB_DAT_I[`CTRL_ICLR_BIT] |
                               (ctrl_r.iclr & (state_r != S_INTG));
            end
          end
          `ADDR_SETPOINT: setpoint_r <= merge16(setpoint_r, WB_DAT_I,
                                                WB_SEL_I);
          `ADDR_PGAIN:    pgain_r <= merge16(pgain_r, WB_DAT_I, WB_SEL_I);
          `ADDR_ISET:     iset_r <= merge16(iset_r, WB_DAT_I, WB_SEL_I);
          `ADDR_DSET: begin
            if (merge16(dset_r, WB_DAT_I, WB_SEL_I) > `DSET_MAX)
              dset_r <= `DSET_MAX;
            else
              dset_r <= merge16(dset_r, WB_DAT_I, WB_SEL_I);
          end
          `ADDR_MANPWR: begin
            if (merge16(manpwr_r, WB_DAT_I, WB_SEL_I) > `FULL_SCALE)
              manpwr_r <= `FULL_SCALE;
            else
              manpwr_r <= merge16(manpwr_r, WB_DAT_I, WB_SEL_I);
          end
          default: ;
        endcase
      end
    end
  end

  // update tick divider
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == TW'(UPDATE_CYCLES - 1));
      if (tick_cnt_r == TW'(UPDATE_CYCLES - 1))
        tick_cnt_r <= '0;
      else
        tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  // arithmetic of the control law
  assign pprod   = $signed({1'b0, pgain_r}) * err_r;
  assign derr    = 18'(err_r) - 18'(err_prev_r);
  assign dprod   = $signed({1'b0, pgain_r}) * derr;
  // magnitude of the scaled error step, sign kept apart
  assign dabs    = dprod[34] ? -dprod : dprod;
  assign dsat    = sat22(50'(dabs >>> `P_SHIFT));
  // integral step: gain*err*I/1000 per second of update
  assign acc_sum = acc_r +
                   48'(pterm_r) * 48'($signed({1'b0, iset_r}));
  assign integ   = acc_r / ISCALE;
  // derivative time = D/100 * (1000/4)/I seconds
  assign use_d   = loop_on & (iset_r != 16'h0000) &
                   (dset_r != 16'h0000);
  // numerator and denominator of the rate division
  assign div_num = 48'(dmag_r) * 48'(dset_r[7:0]) * 48'(DK);
  assign div_den = 24'(iset_r) * 24'(`D_PERCENT);
  assign div_start = (state_r == S_INTG) & use_d;

  pid_div #(
    .NW (48),
    .DW (24)
  ) u_div (
    .clk     (CLK),
    .reset_n (RESET_N),
    .start   (div_start),
    .num     (div_num),
    .den     (div_den),
    .done    (div_done),
    .quot    (div_quot)
  );

  // output sum of all terms while the loop runs, manual power alone otherwise
  always_comb begin
    if (loop_on)
      total = 50'($signed({1'b0, manpwr_r})) + 50'(pterm_r) +
              50'(integ) + 50'(dterm_r);
    else
      total = 50'($signed({1'b0, manpwr_r}));
  end

  // clamp decode of the summed drive
  assign over_fs    = total > 50'($signed({1'b0, `FULL_SCALE}));
  assign under_zero = total < 50'sh0;

  // update sequence, one pass per tick
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r    <= S_IDLE;
      fb_r       <= 16'h0000;
      err_r      <= 17'sh00000;
      err_prev_r <= 17'sh00000;
      pterm_r    <= 22'sh000000;
      dterm_r    <= 22'sh000000;
      dneg_r     <= 1'b0;
      dmag_r     <= 20'h00000;
      acc_r      <= 48'sh0;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (tick_r) begin
            fb_r       <= FEEDBACK;
            err_r      <= $signed({1'b0, setpoint_r}) -
                          $signed({1'b0, FEEDBACK});
            // previous error kept for the rate term
            err_prev_r <= err_r;
            state_r    <= S_PROP;
          end
        end
        S_PROP: begin
          // zero error gives zero proportional term
          pterm_r <= sat22(50'(pprod >>> `P_SHIFT));
          // sign and size of the rate term for the divider
          dneg_r  <= dprod[34];
          dmag_r  <= dsat[19:0];
          state_r <= S_INTG;
        end
        S_INTG: begin
          // cleared when off, with I at zero or on a pending clear, else summed within the limit
          if (!loop_on || iset_r == 16'h0000 || ctrl_r.iclr)
            acc_r <= 48'sh0;
          else if (acc_sum > AMAX)
            acc_r <= AMAX;
          else if (acc_sum < -AMAX)
            acc_r <= -AMAX;
          else
            acc_r <= acc_sum;
          if (use_d) begin
            state_r <= S_DIV;
          end else begin
            dterm_r <= 22'sh000000;
            state_r <= S_SUM;
          end
        end
        S_DIV: begin
          // hold here until the divider answers once
          if (div_done) begin
            if (dneg_r)
              dterm_r <= sat22(-$signed({2'b00, div_quot}));
            else
              dterm_r <= sat22($signed({2'b00, div_quot}));
            state_r <= S_SUM;
          end
        end
        S_SUM: state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // status bits seen by software
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      stat_r <= '0;
    end else begin
      stat_r.loop_on <= loop_on;
      if (state_r == S_SUM) begin
        stat_r.sat_hi <= over_fs;
        stat_r.sat_lo <= under_zero;
      end
    end
  end

  // clamped heater drive, reloaded once per pass
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HEATER_OUT    <= 16'h0000;
      HEATER_UPDATE <= 1'b0;
    end else begin
      HEATER_UPDATE <= (state_r == S_SUM);
      if (state_r == S_SUM) begin
        if (over_fs)
          HEATER_OUT <= `FULL_SCALE;
        else if (under_zero)
          HEATER_OUT <= 16'h0000;
        else
          HEATER_OUT <= total[15:0];
      end
    end
  end

endmodule

// file: sim/pid_law_monitor.sv
`timescale 1ns/1ps
module pid_law_monitor
  import pid_pkg::*;
#(
  parameter int UPDATE_CYCLES = 100
) (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RESET_N,
  // bus
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  // heater
  input wire logic [15:0] HEATER_OUT,
  input wire logic        HEATER_UPDATE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // cycles since the last heater reload, saturating
  logic [15:0] gap_r;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      gap_r <= 16'hFFFF;
    end else if (HEATER_UPDATE) begin
      gap_r <= 16'h0000;
    end else if (gap_r != 16'hFFFF) begin
      gap_r <= gap_r + 16'h0001;
    end
  end

  // bus request and single ack pulse
  sequence s_req;
    WB_CYC_I && WB_STB_I;
  endsequence
  sequence s_ack_once;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence

  AST_ACK_LAT: assert property ($rose(WB_CYC_I && WB_STB_I) |=> WB_ACK_O)
    else $error("ack not one cycle after request");
  AST_ACK_PULSE: assert property (WB_ACK_O |-> s_ack_once)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h00000000)
    else $error("read data outside ack");
  AST_UPD_PULSE: assert property (HEATER_UPDATE |=> !HEATER_UPDATE [*8])
    else $error("update pulse too long");
  AST_HEAT_MAX: assert property (HEATER_OUT <= 16'h2710)
    else $error("heater above full scale");
  AST_HEAT_HOLD: assert property ($changed(HEATER_OUT) |-> HEATER_UPDATE)
    else $error("heater changed without update");
  AST_UPD_GAP: assert property (HEATER_UPDATE |-> gap_r >= UPDATE_CYCLES - 50)
    else $error("updates too close");
  cover property (s_req ##1 s_ack_once);
endmodule

bind pid_heater_control_law pid_law_monitor #(
  .UPDATE_CYCLES(UPDATE_CYCLES)
) mon (
  .CLK(CLK), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .HEATER_OUT(HEATER_OUT),
  .HEATER_UPDATE(HEATER_UPDATE)
);

// file: sim/heater_plant.sv
`timescale 1ns/1ps
module heater_plant (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // load temperature set by the bench
  input wire logic [15:0] temp,
  // sensor reading
  output logic     [15:0] feedback
);
  // sensor converts the load temperature every clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      feedback <= 16'h0000;
    end else begin
      feedback <= temp;
    end
  end
endmodule

// file: sim/pid_heater_control_law_tb_top.sv
`timescale 1ns/1ps
`include "pid_defs.svh"
module pid_heater_control_law_tb_top;
  import pid_pkg::*;
  logic               CLK, RESET_N, cyc, stb, we, ack, upd;
  logic [7:0]         adr;
  logic [31:0]        wdat, dato, rdat;
  logic [15:0]        fb, heat, temp, lfsr, sp, f, m, h1;
  logic signed [17:0] e;
  int                 errors, num_checks, cycles, i;

  pid_heater_control_law #(.UPDATE_CYCLES(100)) dut (
    .CLK(CLK), .RESET_N(RESET_N), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
    .WB_DAT_O(dato), .WB_ACK_O(ack), .FEEDBACK(fb), .HEATER_OUT(heat),
    .HEATER_UPDATE(upd));
  heater_plant plant (.clk(CLK), .reset_n(RESET_N), .temp(temp),
    .feedback(fb));

  // pseudo random source
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  // expected drive: manual power plus unity gain error, clamped
  function automatic logic [15:0] law(logic [15:0] mp, logic signed [17:0] er);
    logic signed [19:0] t;
    t = $signed({4'h0, mp}) + er;
    if (t < 0) return 16'h0000;
    if (t > 20'sh02710) return 16'h2710;
    return t[15:0];
  endfunction
  // expected closed drive at unity gain, k passes of a held step e
  function automatic logic [15:0] pid(int e, int i, int d, int k);
    int t;
    t = e + (k * e * i) / (`I_NUMER * `UPDATE_HZ) +
        (e * d * `D_QUARTER * `UPDATE_HZ) / (`D_PERCENT * i);
    return 16'(t);
  endfunction

  task automatic chk(logic [31:0] g, logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // one classic wishbone cycle
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge CLK);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge CLK); while (ack !== 1'b1);
    rdat = dato;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic wait_upd(int n);
    repeat (n) do @(posedge CLK); while (upd !== 1'b1);
  endtask
  task automatic give_verdict();
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  // hang guard
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end
  // main sequence
  initial begin
    RESET_N = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
    wdat = 32'h0; temp = 16'h0; lfsr = 16'h0011; cycles = 0;
    repeat (6) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    chk(heat, 32'h0);
    wb(1'b1, `ADDR_DSET, 32'hFFFF);
    wb(1'b0, `ADDR_DSET, 32'h0);
    chk(rdat, `DSET_MAX);
    wb(1'b1, `ADDR_MANPWR, 32'hFFFF);
    wb(1'b0, `ADDR_MANPWR, 32'h0);
    chk(rdat, `FULL_SCALE);
    wb(1'b1, `ADDR_DSET, 32'h0);
    wb(1'b1, 8'h3C, 32'hFFFF);
    wb(1'b0, 8'h3C, 32'h0);
    chk(rdat, 32'h0);
    // closed loop with zero gain keeps manual power only
    m = rnd() % 16'h2711;
    temp <= rnd();
    wb(1'b1, `ADDR_CTRL, 32'h1);
    wb(1'b1, `ADDR_SETPOINT, {16'h0, rnd()});
    wb(1'b1, `ADDR_MANPWR, {16'h0, m});
    wait_upd(2);
    chk(heat, m);
    wb(1'b1, `ADDR_PGAIN, 32'h100);
    for (i = 0; i < 8; i++) begin
      sp = rnd() & 16'h0FFF;
      f = (i == 0) ? sp : rnd() & 16'h0FFF;
      m = (i < 2) ? 16'h0 : rnd() % 16'h2711;
      if (i == 1) sp = 16'hFFF0;
      e = $signed({2'b00, sp}) - $signed({2'b00, f});
      temp <= f;
      wb(1'b1, `ADDR_SETPOINT, {16'h0, sp});
      wb(1'b1, `ADDR_MANPWR, {16'h0, m});
      wait_upd(2);
      chk(heat, law(m, e));
      wb(1'b0, `ADDR_ERROR, 32'h0);
      chk(rdat, {{14{e[17]}}, e});
    end
    // integral term: 5 per update at this setting
    wb(1'b1, `ADDR_MANPWR, 32'h0);
    temp <= 16'd995;
    wb(1'b1, `ADDR_SETPOINT, 32'd1000);
    wb(1'b1, `ADDR_ISET, 32'd10000);
    wait_upd(2);
    h1 = heat;
    wait_upd(1);
    chk(heat - h1, 32'h5);
    temp <= 16'd1000;
    wait_upd(2);
    h1 = heat;
    wait_upd(1);
    chk(heat, h1);
    wb(1'b1, `ADDR_ISET, 32'h0);
    wait_upd(2);
    chk(heat, 32'h0);
    // rate term: one step of error with I and D on
    wb(1'b1, `ADDR_DSET, 32'd100);
    wb(1'b1, `ADDR_ISET, 32'd1000);
    wait_upd(2);
    temp <= 16'd960;
    wait_upd(1);
    chk(heat, pid(40, 1000, 100, 1));
    wait_upd(1);
    chk(heat, pid(40, 1000, 0, 2));
    // integrator clear is one-shot and reads back idle
    wb(1'b1, `ADDR_CTRL, 32'h3);
    wait_upd(1);
    chk(heat, pid(40, 1000, 0, 0));
    wb(1'b0, `ADDR_CTRL, 32'h0);
    chk(rdat, 32'h1);
    wb(1'b0, `ADDR_STATUS, 32'h0);
    chk(rdat, 32'h1);
    wb(1'b0, `ADDR_FEEDBACK, 32'h0);
    chk(rdat, 32'd960);
    wb(1'b0, `ADDR_HEATER, 32'h0);
    chk(rdat, {16'h0, pid(40, 1000, 0, 0)});
    // open loop ignores the sensor
    m = rnd() % 16'h2711;
    wb(1'b1, `ADDR_CTRL, 32'h0);
    wb(1'b1, `ADDR_MANPWR, {16'h0, m});
    temp <= rnd();
    wait_upd(2);
    chk(heat, m);
    give_verdict();
  end
endmodule
